// ### shared/mac_coproc_regs.vh
// Constants for the multiply-accumulate coprocessor
`ifndef MAC_COPROC_REGS_VH
`define MAC_COPROC_REGS_VH
// ==========================================
// Widths
`define ACC_WIDTH        40
`define ACC_RESET        40'h00_0000_0000
// ==========================================
// Operation codes
`define OP_HALF_WORD_MAC 3'h0
`define OP_DUAL_HALF_MAC 3'h1
`define OP_WORD_MAC      3'h2
`define OP_ACC_TO_REGS   3'h3
`define OP_REGS_TO_ACC   3'h4
`define OP_STORE_XFER    3'h5
`define OP_LOAD_XFER     3'h6
// ==========================================
// Half selects: bit 1 multiplier, bit 0 multiplicand; 1 means high half
`define SEL_HIGH_BIT     1
`define SEL_LOW_BIT      0
// Upper accumulator byte position
`define ACC_UPPER_MSB    39
`define ACC_UPPER_LSB    32
`endif

// ### rtl/signed_mult.v
// Registered-free signed multiplier used by the accumulator datapath
`timescale 1ns/1ps
module signed_mult #(
    parameter A_WIDTH = 32,
    parameter B_WIDTH = 32
) (
    input  wire signed [A_WIDTH-1:0]         a,
    input  wire signed [B_WIDTH-1:0]         b,
    output wire signed [A_WIDTH+B_WIDTH-1:0] product
);
    // Full-width product, no truncation
    assign product = a * b;
endmodule // signed_mult

// ### rtl/mac_coprocessor.v
// Multiply-accumulate coprocessor with a 40-bit accumulator
// What this block does
// [RL1] One 40-bit signed accumulator; single, dual and word signed MACs add into it.
// [RL2] Accumulator-to-registers move hands the whole 40-bit value to two registers.
// [RL3] Registers-to-accumulator move loads all 40 bits from two registers.
// [RL4] Memory save or restore takes two transfers, one part each.
// [RL5] Single MAC picks high or low halves of both operands, signed.
// [RL6] Single MAC forms 32-bit signed product, sign-extends to 40, accumulates.
// [RL7] Dual MAC multiplies high pair and low pair, both added sign-extended.
// [RL8] Word MAC forms the 64-bit product, adds its low 40 bits.
// [RL9] The 32-by-32 word MAC finishes in one cycle.
// [RL10] Accumulation wraps modulo two to the fortieth, no saturation, no flag.
// [RL11] Low register gets bits 31..0, other register gets 39..32 in low byte.
`timescale 1ns/1ps
`include "mac_coproc_regs.vh"
module mac_coprocessor (
    input  wire        clock,
    input  wire        resetn,
    input  wire        op_valid,
    input  wire [2:0]  op_code,
    input  wire [1:0]  half_sel,
    input  wire        xfer_part,
    input  wire [31:0] multiplier,
    input  wire [31:0] multiplicand,
    input  wire [31:0] load_data,
    output reg  [31:0] result_lo,
    output reg  [31:0] result_hi,
    output reg         result_valid,
    output reg  [39:0] acc_out
);
    // ==========================================
    // Operand selection
    wire signed [15:0] mul_half = half_sel[`SEL_HIGH_BIT] ? multiplier[31:16] : multiplier[15:0]; // RL5
    wire signed [15:0] mcd_half = half_sel[`SEL_LOW_BIT] ? multiplicand[31:16] : multiplicand[15:0]; // RL5
    wire signed [31:0] prod_single;
    wire signed [31:0] prod_hh;
    wire signed [31:0] prod_ll;
    wire signed [63:0] prod_word;

    signed_mult #(.A_WIDTH(16), .B_WIDTH(16)) u_single (
        .a       (mul_half),
        .b       (mcd_half),
        .product (prod_single)
    );
    signed_mult #(.A_WIDTH(16), .B_WIDTH(16)) u_high (
        .a       (multiplier[31:16]),
        .b       (multiplicand[31:16]),
        .product (prod_hh)
    );
    signed_mult #(.A_WIDTH(16), .B_WIDTH(16)) u_low (
        .a       (multiplier[15:0]),
        .b       (multiplicand[15:0]),
        .product (prod_ll)
    );
    // Full product computed combinationally so every variant completes in one cycle
    signed_mult #(.A_WIDTH(32), .B_WIDTH(32)) u_word (
        .a       (multiplier),
        .b       (multiplicand),
        .product (prod_word)
    ); // RL9

    // ==========================================
    // Accumulator next value
    wire [39:0] ext_single = {{8{prod_single[31]}}, prod_single}; // RL6
    wire [39:0] ext_hh     = {{8{prod_hh[31]}}, prod_hh}; // RL7
    wire [39:0] ext_ll     = {{8{prod_ll[31]}}, prod_ll}; // RL7
    wire [39:0] word_low   = prod_word[39:0]; // RL8

    reg  [39:0] acc_reg;
    reg  [39:0] acc_next;
    reg  [31:0] lo_next;
    reg  [31:0] hi_next;
    reg         valid_next;

    always @* begin
        acc_next   = acc_reg;
        lo_next    = result_lo;
        hi_next    = result_hi;
        valid_next = 1'b0;
        if (op_valid) begin
            case (op_code)
                `OP_HALF_WORD_MAC: begin
                    acc_next = acc_reg + ext_single; // RL1 RL10
                end
                `OP_DUAL_HALF_MAC: begin
                    acc_next = acc_reg + ext_hh + ext_ll; // RL1 RL10
                end
                `OP_WORD_MAC: begin
                    acc_next = acc_reg + word_low; // RL1 RL10
                end
                `OP_ACC_TO_REGS: begin
                    lo_next    = acc_reg[31:0]; // RL2 RL11
                    hi_next    = {24'h00_0000, acc_reg[`ACC_UPPER_MSB:`ACC_UPPER_LSB]}; // RL11
                    valid_next = 1'b1;
                end
                `OP_REGS_TO_ACC: begin
                    acc_next = {multiplicand[7:0], multiplier}; // RL3
                end
                `OP_STORE_XFER: begin
                    // Part 0 gives the low word, part 1 the upper byte
                    if (xfer_part) begin
                        lo_next = {24'h00_0000, acc_reg[`ACC_UPPER_MSB:`ACC_UPPER_LSB]}; // RL4
                    end else begin
                        lo_next = acc_reg[31:0]; // RL4
                    end
                    hi_next    = 32'h0000_0000;
                    valid_next = 1'b1;
                end
                `OP_LOAD_XFER: begin
                    // Each part replaces only its own slice, so order is free
                    if (xfer_part) begin
                        acc_next = {load_data[7:0], acc_reg[31:0]}; // RL4
                    end else begin
                        acc_next = {acc_reg[`ACC_UPPER_MSB:`ACC_UPPER_LSB], load_data}; // RL4
                    end
                end
                default: begin
                    acc_next = acc_reg;
                end
            endcase
        end
    end

    // ==========================================
    // State
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc_reg      <= `ACC_RESET;
            acc_out      <= `ACC_RESET;
            result_lo    <= 32'h0000_0000;
            result_hi    <= 32'h0000_0000;
            result_valid <= 1'b0;
        end else begin
            acc_reg      <= acc_next;
            acc_out      <= acc_next;
            result_lo    <= lo_next;
            result_hi    <= hi_next;
            result_valid <= valid_next;
        end
    end
endmodule // mac_coprocessor

// ### sim/mac_chk.sv
// Port assertions for the coprocessor
`timescale 1ns/1ps
module mac_chk (
    input logic clock, resetn, op_valid, xfer_part, result_valid, input logic [2:0] op_code,
    input logic [1:0] half_sel, input logic [39:0] acc_out,
    input logic [31:0] multiplier, multiplicand, load_data, result_lo, result_hi);
    wire [7:0] go = {7'h0, op_valid} << op_code;
    wire signed [15:0] hm = half_sel[1] ? multiplier[31:16] : multiplier[15:0];
    wire signed [15:0] hc = half_sel[0] ? multiplicand[31:16] : multiplicand[15:0];
    wire signed [31:0] ph = hm * hc;
    wire [63:0] pw = $signed(multiplier) * $signed(multiplicand);
    wire signed [31:0] pa = $signed(multiplier[31:16]) * $signed(multiplicand[31:16]);
    wire signed [31:0] pb = $signed(multiplier[15:0]) * $signed(multiplicand[15:0]);
    wire [39:0] e_d = acc_out + 40'(pa) + 40'(pb);
    wire [39:0] e_h = acc_out + 40'(ph), e_w = acc_out + pw[39:0], e_r = {multiplicand[7:0], multiplier};
    wire [39:0] e_l = xfer_part ? {load_data[7:0], acc_out[31:0]} : {acc_out[39:32], load_data};
    wire [31:0] e_s = xfer_part ? {24'h0, acc_out[39:32]} : acc_out[31:0];
    wire rq = go[3] | go[5], idle = ~|go[6:0];
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    chk_half_mac_sum: assert property (go[0] |=> acc_out == $past(e_h)) else $error("half mac");
    chk_dual_mac_sum: assert property (go[1] |=> acc_out == $past(e_d)) else $error("dual mac");
    chk_word_mac_sum: assert property (go[2] |=> acc_out == $past(e_w)) else $error("word mac");
    chk_acc_out_move: assert property (go[3] |=> {result_hi, result_lo} == {24'h0, $past(acc_out)}) else $error("out");
    chk_acc_in_move: assert property (go[4] |=> acc_out == $past(e_r)) else $error("in");
    chk_store_part: assert property (go[5] |=> result_lo == $past(e_s) && result_hi == 0) else $error("store");
    chk_load_part: assert property (go[6] |=> acc_out == $past(e_l)) else $error("load");
    chk_valid_pulse: assert property (result_valid == $past(rq)) else $error("valid");
    chk_idle_hold: assert property (idle |=> $stable(acc_out)) else $error("idle");
endmodule // mac_chk
bind mac_coprocessor mac_chk u_chk (.*);

// ### sim/host_core_model.sv
// Host core model: one request per call
`timescale 1ns/1ps
module host_core_model (input logic clock, output logic op_valid = 0, xfer_part = 0, output logic [2:0] op_code = 0,
    output logic [1:0] half_sel = 0, output logic [31:0] multiplier = 0, multiplicand = 0, load_data = 0);
    task issue(input logic [4:0] c, input logic [31:0] a, b);
        @(posedge clock);
        {op_valid, op_code, half_sel, xfer_part} <= {1'b1, c, c[0]};
        {multiplier, multiplicand, load_data} <= {a, b, a};
        @(posedge clock);
        // Released operands are scrambled so stale values cannot pass
        {op_valid, multiplier, multiplicand, load_data} <= {1'b0, ~a, ~b, ~a};
    endtask
endmodule // host_core_model

// ### sim/multiply_accumulate_coprocessor_bench.sv
// Self-checking bench for the coprocessor
`timescale 1ns/1ps
module multiply_accumulate_coprocessor_bench;
    typedef struct packed {logic [4:0] c; logic [31:0] a, b; logic [39:0] e;} row_t;
    logic clock = 0, resetn = 0, op_valid, xfer_part, result_valid;
    logic [2:0] op_code;
    logic [1:0] half_sel;
    logic [31:0] multiplier, multiplicand, load_data, result_lo, result_hi;
    logic [39:0] acc_out;
    int n_fail = 0, num_checks = 0, cyc = 0;
    row_t t [12] = '{'{5'h10, 32'hFFFF_FFF0, 32'h0000_00FF, 40'hFF_FFFF_FFF0},
        '{5'h03, 32'h0002_0000, 32'hFFFD_0000, 40'hFF_FFFF_FFEA}, '{5'h00, 32'h0000_8000, 32'h0000_8000, 40'h3FFF_FFEA},
        '{5'h02, 32'h0003_0000, 32'h0000_0004, 40'h3FFF_FFF6}, '{5'h01, 32'h0000_0005, 32'h0006_0000, 40'h4000_0014},
        '{5'h04, 32'h0002_FFFF, 32'h0003_0005, 40'h4000_0015}, '{5'h08, 32'h7FFF_FFFF, 32'h0000_0200, 40'h3FFF_FE15},
        '{5'h0C, 32'h0, 32'h0, 40'h3FFF_FE15}, '{5'h15, 32'h0, 32'h0, 40'h3FFF_FE15},
        '{5'h18, 32'h1234_5678, 32'h0, 40'h1234_5678}, '{5'h19, 32'h0000_00A5, 32'h0, 40'hA5_1234_5678},
        '{5'h14, 32'h0, 32'h0, 40'hA5_1234_5678}};
    host_core_model u_host (.*);
    mac_coprocessor u_dut (.*);
    initial forever #4 clock = ~clock;
    always @(posedge clock) if (++cyc == 500) begin n_fail++; summarize(); end
    task chk(input logic [63:0] g, x);
        num_checks++;
        if (g !== x) begin n_fail++; $display("Error at %0t: got %h want %h", $time, g, x); end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1;
        #1 chk(acc_out, 40'h0);
        foreach (t[i]) begin
            u_host.issue(t[i].c, t[i].a, t[i].b);
            #1 chk(acc_out, t[i].e);
            chk(result_valid, t[i].c[4:2] inside {3'h3, 3'h5});
        end
        // Hand cases: a non-zero upper byte must reach both move and store outputs
        u_host.issue(5'h0C, 32'h0000_0000, 32'h0000_0000);
        #1 chk({result_hi, result_lo}, 64'h0000_00A5_1234_5678);
        u_host.issue(5'h15, 32'h0000_0000, 32'h0000_0000);
        #1 chk({result_hi, result_lo}, 64'h0000_0000_0000_00A5);
        // Unused operation code must leave the accumulator alone
        u_host.issue(5'h1C, 32'h0000_1111, 32'h0000_2222);
        #1 chk(acc_out, 40'hA5_1234_5678);
        @(posedge clock) resetn <= 0;
        @(posedge clock) resetn <= 1;
        #1 chk(acc_out, 40'h0);
        summarize();
    end
endmodule // multiply_accumulate_coprocessor_bench
